// ===== include/ep_consts.svh
`ifndef EP_CONSTS_SVH
`define EP_CONSTS_SVH

// Bus widths of the parallel memory and the delay counter width.
`define EP_ADDR_W 17
`define EP_DATA_W 8
`define EP_CNT_W 22

// Clock period and the pin timing figures.
`define EP_CLK_NS 4
`define EP_T_WP_NS 350
`define EP_T_BLC_NS 950
`define EP_T_ACC_NS 200
`define EP_T_WC_MS 10
`define EP_T_RP_US 100
`define EP_WP_CYC ((`EP_T_WP_NS + `EP_CLK_NS - 1) / `EP_CLK_NS)
`define EP_BLC_CYC ((`EP_T_BLC_NS + `EP_CLK_NS - 1) / `EP_CLK_NS)
`define EP_ACC_CYC ((`EP_T_ACC_NS + `EP_CLK_NS - 1) / `EP_CLK_NS)
`define EP_WC_CYC ((`EP_T_WC_MS * 1000000 + `EP_CLK_NS - 1) / `EP_CLK_NS)
`define EP_RP_CYC ((`EP_T_RP_US * 1000 + `EP_CLK_NS - 1) / `EP_CLK_NS)

// Protection command addresses and data.
`define EP_SDP_ADDR_A 17'h05555
`define EP_SDP_ADDR_B 17'h02aaa
`define EP_SDP_D_AA 8'haa
`define EP_SDP_D_55 8'h55
`define EP_SDP_D_EN 8'ha0
`define EP_SDP_D_80 8'h80
`define EP_SDP_D_DIS 8'h20

// Sequence positions.
`define EP_IDX_USER 3'h3
`define EP_IDX_EN_LAST 3'h2
`define EP_IDX_DIS_LAST 3'h5

`endif

// ===== include/ep_pkg.sv
`default_nettype none
`include "ep_consts.svh"

package ep_pkg;
    typedef enum logic [1:0] {
        EP_CMD_READ,
        EP_CMD_WRITE,
        EP_CMD_SDP_ON,
        EP_CMD_SDP_OFF
    } ep_cmd_t;

    typedef enum logic [2:0] {
        EP_ST_OFF,
        EP_ST_IDLE,
        EP_ST_SETUP,
        EP_ST_STROBE,
        EP_ST_RECOV,
        EP_ST_READ,
        EP_ST_HOLD
    } ep_state_t;

    typedef struct packed {
        logic [`EP_ADDR_W-1:0] addr;
        logic [`EP_DATA_W-1:0] dq_o;
        logic dq_oe_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic write_guard_n;
    } ep_pins_t;

    typedef struct packed {
        ep_state_t st;
        ep_cmd_t cmd;
        logic sdp_on;
        logic [2:0] idx;
        logic [2:0] last;
        logic [`EP_CNT_W-1:0] cnt;
        logic [`EP_ADDR_W-1:0] uaddr;
        logic [`EP_DATA_W-1:0] udata;
        logic [`EP_DATA_W-1:0] rdata;
        logic rdy;
        logic done;
        ep_pins_t pins;
    } ep_regs_t;
endpackage
`default_nettype wire

// ===== core/ep_host_ctrl.sv
// Notes on behaviour
// RULE1 - Guard low blocks device reads and programming.
// RULE2 - Guard stays high through every access.
// RULE3 - Device filters strobe pulses of 20ns or less.
// RULE4 - Strobes come clean from flops, no glitches.
// RULE5 - Guard held low while supply not good.
// RULE6 - Guard falling aborts a running program.
// RULE7 - Guard high 10 ms after last byte.
// RULE8 - Protected writes carry a three-byte unlock prefix.
// RULE9 - Three-byte sequence turns software protection on.
// RULE10 - Six-byte sequence cancels software protection.
// RULE11 - After cancel, writes need no prefix.
// RULE12 - Cancel sequence bytes are never stored.
// RULE13 - Address on strobe fall, data on rise.
// RULE14 - Unlock is AA/5555, 55/2AAA, A0/5555.
// RULE15 - Protected device ignores unprefixed writes.
`timescale 1ns/1ps
`default_nettype none
`include "ep_consts.svh"

module ep_host_ctrl #(
    parameter int unsigned HOLD_CYCLES = `EP_WC_CYC,
    parameter int unsigned RELEASE_CYCLES = `EP_RP_CYC,
    parameter logic SDP_INIT = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_ok,
    input wire logic cmd_valid,
    input var ep_pkg::ep_cmd_t cmd,
    input wire logic [`EP_ADDR_W-1:0] cmd_addr,
    input wire logic [`EP_DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic done,
    output logic [`EP_DATA_W-1:0] rdata,
    output logic sdp_active,
    output logic [`EP_ADDR_W-1:0] mem_addr,
    output logic [`EP_DATA_W-1:0] dq_o,
    output logic dq_oe_n,
    input wire logic [`EP_DATA_W-1:0] dq_i,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic write_guard_n
);
    import ep_pkg::*;

    localparam logic [`EP_CNT_W-1:0] WP_C = `EP_CNT_W'(`EP_WP_CYC);
    localparam logic [`EP_CNT_W-1:0] BLC_C = `EP_CNT_W'(`EP_BLC_CYC);
    localparam logic [`EP_CNT_W-1:0] ACC_C = `EP_CNT_W'(`EP_ACC_CYC);
    localparam logic [`EP_CNT_W-1:0] HOLD_C = `EP_CNT_W'(HOLD_CYCLES);
    localparam logic [`EP_CNT_W-1:0] REL_C = `EP_CNT_W'(RELEASE_CYCLES);
    localparam int CANCEL_SPAN = `EP_WP_CYC + `EP_BLC_CYC + 2; // Last cancel strobe to mode clear, one cycle spare.

    ep_regs_t q, d;

    // Address and data of one byte of a sequence; the cancel table never carries user data.
    function automatic logic [`EP_ADDR_W+`EP_DATA_W-1:0] seq_byte(
        input logic dis,
        input logic [2:0] idx,
        input logic [`EP_ADDR_W-1:0] ua,
        input logic [`EP_DATA_W-1:0] ud
    );
        logic [`EP_ADDR_W+`EP_DATA_W-1:0] r;
        r = {ua, ud};
        if (dis) begin
            // RULE10 cancel byte table.
            // RULE12 no user data.
            case (idx)
                3'h0: r = {`EP_SDP_ADDR_A, `EP_SDP_D_AA};
                3'h1: r = {`EP_SDP_ADDR_B, `EP_SDP_D_55};
                3'h2: r = {`EP_SDP_ADDR_A, `EP_SDP_D_80};
                3'h3: r = {`EP_SDP_ADDR_A, `EP_SDP_D_AA};
                3'h4: r = {`EP_SDP_ADDR_B, `EP_SDP_D_55};
                default: r = {`EP_SDP_ADDR_A, `EP_SDP_D_DIS};
            endcase
        end else begin
            // RULE14 unlock byte table.
            case (idx)
                3'h0: r = {`EP_SDP_ADDR_A, `EP_SDP_D_AA};
                3'h1: r = {`EP_SDP_ADDR_B, `EP_SDP_D_55};
                3'h2: r = {`EP_SDP_ADDR_A, `EP_SDP_D_EN};
                default: r = {ua, ud};
            endcase
        end
        return r;
    endfunction

    // Next-state logic for the whole controller.
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rdy = 1'b0;
        case (q.st)
            EP_ST_OFF: begin
                // RULE2 guard high first; the setup time runs out before any access.
                d.pins.write_guard_n = 1'b1;
                if (q.cnt == '0) begin
                    d.st = EP_ST_IDLE;
                    d.rdy = 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            EP_ST_IDLE: begin
                d.rdy = 1'b1;
                if (cmd_valid) begin
                    d.rdy = 1'b0;
                    d.cmd = cmd;
                    d.uaddr = cmd_addr;
                    d.udata = cmd_wdata;
                    d.pins.addr = cmd_addr;
                    case (cmd)
                        EP_CMD_READ: begin
                            d.st = EP_ST_READ;
                            d.cnt = ACC_C;
                            d.pins.ce_n = 1'b0;
                            d.pins.oe_n = 1'b0;
                        end
                        // RULE8 prefix when protected.
                        // RULE11 no prefix otherwise.
                        EP_CMD_WRITE: begin
                            d.st = EP_ST_SETUP;
                            d.idx = q.sdp_on ? 3'h0 : `EP_IDX_USER;
                            d.last = `EP_IDX_USER;
                        end
                        // RULE9 three bytes enable.
                        EP_CMD_SDP_ON: begin
                            d.st = EP_ST_SETUP;
                            d.idx = 3'h0;
                            d.last = `EP_IDX_EN_LAST;
                        end
                        default: begin
                            d.st = EP_ST_SETUP;
                            d.idx = 3'h0;
                            d.last = `EP_IDX_DIS_LAST;
                        end
                    endcase
                end
            end
            EP_ST_SETUP: begin
                // RULE13 address, data and the falling strobe all load on the same edge.
                {d.pins.addr, d.pins.dq_o} = seq_byte(q.cmd == EP_CMD_SDP_OFF, q.idx, q.uaddr, q.udata);
                d.pins.dq_oe_n = 1'b0;
                d.pins.oe_n = 1'b1;
                d.st = EP_ST_STROBE;
                d.cnt = WP_C - 1'b1;
                d.pins.ce_n = 1'b0;
                d.pins.we_n = 1'b0;
            end
            EP_ST_STROBE: begin
                // RULE4 one clean low pulse per byte.
                if (q.cnt == '0) begin
                    d.pins.we_n = 1'b1;
                    d.pins.ce_n = 1'b1;
                    d.st = EP_ST_RECOV;
                    d.cnt = BLC_C;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            EP_ST_RECOV: begin
                // Data stays driven past the rising strobe for hold time.
                if (q.cnt == '0) begin
                    d.pins.dq_oe_n = 1'b1;
                    if (q.idx == q.last) begin
                        d.st = EP_ST_HOLD;
                        d.cnt = HOLD_C;
                        if (q.cmd == EP_CMD_SDP_ON) begin
                            d.sdp_on = 1'b1;
                        end else if (q.cmd == EP_CMD_SDP_OFF) begin
                            d.sdp_on = 1'b0;
                        end
                    end else begin
                        d.idx = q.idx + 3'h1;
                        d.st = EP_ST_SETUP;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            EP_ST_READ: begin
                if (q.cnt == '0) begin
                    d.rdata = dq_i;
                    d.pins.ce_n = 1'b1;
                    d.pins.oe_n = 1'b1;
                    d.done = 1'b1;
                    d.rdy = 1'b1;
                    d.st = EP_ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            EP_ST_HOLD: begin
                // RULE7 guard high while programming.
                if (q.cnt == '0) begin
                    d.done = 1'b1;
                    d.rdy = 1'b1;
                    d.st = EP_ST_IDLE;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                d.st = EP_ST_OFF;
            end
        endcase
        // RULE5 supply loss forces the guard low.
        if (!power_ok) begin
            d.st = EP_ST_OFF;
            d.cnt = REL_C;
            d.rdy = 1'b0;
            d.pins.write_guard_n = 1'b0;
            d.pins.ce_n = 1'b1;
            d.pins.oe_n = 1'b1;
            d.pins.we_n = 1'b1;
            d.pins.dq_oe_n = 1'b1;
        end
    end

    // State register; reset parks the memory guarded and idle.
    always_ff @(posedge clk) begin
        if (reset) begin
            q <= '{st: EP_ST_OFF, cmd: EP_CMD_READ, sdp_on: SDP_INIT, idx: 3'h0, last: 3'h0,
                   cnt: REL_C, uaddr: '0, udata: '0, rdata: '0, rdy: 1'b0, done: 1'b0,
                   pins: '{addr: '0, dq_o: '0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
                           we_n: 1'b1, write_guard_n: 1'b0}};
        end else begin
            q <= d;
        end
    end

    // Every output is a field of the state register.
    assign cmd_ready = q.rdy;
    assign done = q.done;
    assign rdata = q.rdata;
    assign sdp_active = q.sdp_on;
    assign mem_addr = q.pins.addr;
    assign dq_o = q.pins.dq_o;
    assign dq_oe_n = q.pins.dq_oe_n;
    assign ce_n = q.pins.ce_n;
    assign oe_n = q.pins.oe_n;
    assign we_n = q.pins.we_n;
    assign write_guard_n = q.pins.write_guard_n;

    // Helper counters: strobe low width and cycles since the last write strobe.
    int unsigned wlow, since_we;
    always_ff @(posedge clk) begin
        if (reset) begin
            wlow <= 0;
            since_we <= 0;
        end else begin
            wlow <= q.pins.we_n ? 0 : wlow + 1;
            since_we <= !q.pins.we_n ? 0 : since_we + 1;
        end
    end

    sequence s_first_unlock;
        q.st == EP_ST_STROBE && q.idx == 3'h0;
    endsequence

    a_guard_during_access: assert property (@(posedge clk) disable iff (reset)
        !q.pins.ce_n |-> q.pins.write_guard_n) // RULE2
        else $error("guard low during access");

    a_guard_power_off: assert property (@(posedge clk) disable iff (reset)
        !power_ok |=> !write_guard_n && we_n) // RULE5
        else $error("guard not low while supply is down");

    a_strobe_full_width: assert property (@(posedge clk) disable iff (reset)
        $rose(we_n) && write_guard_n |-> wlow == `EP_WP_CYC) // RULE4
        else $error("write strobe width wrong");

    a_hold_after_write: assert property (@(posedge clk) disable iff (reset)
        q.st == EP_ST_IDLE && $past(q.st) == EP_ST_HOLD |-> since_we > HOLD_CYCLES + `EP_BLC_CYC && write_guard_n) // RULE7
        else $error("guard hold after write too short");

    a_unlock_prefix_sent: assert property (@(posedge clk) disable iff (reset || !power_ok)
        q.st == EP_ST_IDLE && cmd_valid && cmd == EP_CMD_WRITE && q.sdp_on |-> ##2 s_first_unlock) // RULE8
        else $error("protected write without unlock prefix");

    a_unlock_bytes: assert property (@(posedge clk) disable iff (reset)
        $fell(we_n) && q.cmd != EP_CMD_SDP_OFF && q.idx == 3'h2 |->
        mem_addr == `EP_SDP_ADDR_A && dq_o == `EP_SDP_D_EN && !dq_oe_n) // RULE14
        else $error("third unlock byte wrong");

    a_cancel_last_byte: assert property (@(posedge clk) disable iff (reset)
        $fell(we_n) && q.cmd == EP_CMD_SDP_OFF && q.idx == 3'h5 |->
        mem_addr == `EP_SDP_ADDR_A && dq_o == `EP_SDP_D_DIS ##[1:CANCEL_SPAN] !sdp_active) // RULE10
        else $error("cancel sequence end wrong");

    a_cancel_first_byte: assert property (@(posedge clk) disable iff (reset)
        $fell(we_n) && q.cmd == EP_CMD_SDP_OFF && q.idx == 3'h0 |->
        mem_addr == `EP_SDP_ADDR_A && dq_o == `EP_SDP_D_AA) // RULE10
        else $error("cancel sequence start wrong");
endmodule
`default_nettype wire

// ===== test/ep_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ep_consts.svh"

module ep_mem_model #(
    parameter real PROG_NS = 60.0
) (
    input wire logic [`EP_ADDR_W-1:0] mem_addr,
    input wire logic [`EP_DATA_W-1:0] dq_bus,
    output logic [`EP_DATA_W-1:0] dq_dev,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic write_guard_n,
    output logic sdp,
    output int viol
);
    logic [`EP_DATA_W-1:0] mem [logic [`EP_ADDR_W-1:0]];
    logic [`EP_ADDR_W-1:0] la;
    logic [2:0] step = 3'h0;
    logic unl = 1'b0;
    logic pend = 1'b0;
    realtime t_fall;
    wire logic wr_act = !we_n && !ce_n;
    wire logic rd_act = !ce_n && !oe_n && write_guard_n;

    initial sdp = 1'b0;
    initial viol = 0;
    initial dq_dev = 8'h00;

    // guard blocks reads.
    // An idle bus flips its last value so stale data never passes for a read.
    always @(rd_act, mem_addr) begin
        if (rd_act) begin
            dq_dev = mem.exists(mem_addr) ? mem[mem_addr] : 8'hff;
        end else begin
            dq_dev = ~dq_dev;
        end
    end

    always @(posedge wr_act) begin
        la = mem_addr;
        t_fall = $realtime;
    end

    always @(negedge wr_act) begin
        if (write_guard_n && ($realtime - t_fall > 20.0)) begin
            take_byte(la, dq_bus);
        end
    end

    // sequence decoding.
    // A plain AA written to the first command address is taken as a command; a known limitation.
    task automatic take_byte(input logic [`EP_ADDR_W-1:0] a, input logic [`EP_DATA_W-1:0] d);
        logic is_a;
        logic is_b;
        is_a = (a == `EP_SDP_ADDR_A);
        is_b = (a == `EP_SDP_ADDR_B) || (a == 17'h0aaaa);
        if (step == 3'h0 && is_a && d == `EP_SDP_D_AA) step = 3'h1;
        else if (step == 3'h1 && is_b && d == `EP_SDP_D_55) step = 3'h2;
        else if (step == 3'h2 && is_a && d == `EP_SDP_D_80) step = 3'h3;
        else if (step == 3'h3 && is_a && d == `EP_SDP_D_AA) step = 3'h4;
        else if (step == 3'h4 && is_b && d == `EP_SDP_D_55) step = 3'h5;
        else if (step == 3'h2 && is_a && d == `EP_SDP_D_EN) begin
            step = 3'h0;
            sdp = 1'b1;
            unl = 1'b1;
        end else if (step == 3'h5 && is_a && d == `EP_SDP_D_DIS) begin
            step = 3'h0;
            sdp = 1'b0;
            unl = 1'b0;
        end else begin
            step = 3'h0;
            if (!sdp || unl) begin
                pend = 1'b1;
                fork
                    begin
                        #(PROG_NS);
                        if (pend) mem[a] = d;
                        pend = 1'b0;
                    end
                join_none
            end
            unl = 1'b0;
        end
    endtask

    always @(negedge write_guard_n) begin
        pend = 1'b0;
        if (ce_n === 1'b0) viol++;
    end

    always @(negedge ce_n) begin
        if (write_guard_n !== 1'b1) viol++;
    end
endmodule

`default_nettype wire

// ===== test/ep_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ep_consts.svh"

module tb;
    import ep_pkg::*;
    localparam int unsigned REL = 10;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic power_ok = 1'b0;
    logic cmd_valid = 1'b0;
    ep_cmd_t cmd = EP_CMD_READ;
    logic [`EP_ADDR_W-1:0] cmd_addr = 17'h00000;
    logic [`EP_DATA_W-1:0] cmd_wdata = 8'h00;
    logic cmd_ready, done, sdp_active, dq_oe_n, ce_n, oe_n, we_n, write_guard_n, sdp_dev;
    logic hold_on = 1'b0;
    logic [`EP_DATA_W-1:0] rdata, dq_o, dq_dev, dq_bus;
    logic [`EP_ADDR_W-1:0] mem_addr;
    int viol;
    int guard_bad = 0;
    int num_errors = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;
    // The host owns the data wire only while its enable is low.
    assign dq_bus = dq_oe_n ? dq_dev : dq_o;

    ep_host_ctrl #(.HOLD_CYCLES(20), .RELEASE_CYCLES(REL)) dut_u (.clk(clk), .reset(reset),
        .power_ok(power_ok), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .done(done), .rdata(rdata), .sdp_active(sdp_active), .mem_addr(mem_addr),
        .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_bus), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .write_guard_n(write_guard_n));
    ep_mem_model mem_u (.mem_addr(mem_addr), .dq_bus(dq_bus), .dq_dev(dq_dev), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .write_guard_n(write_guard_n), .sdp(sdp_dev), .viol(viol));

    // Guard must stay high over any access and from a strobe until its done, unless power drops.
    always @(negedge clk) begin
        if (we_n === 1'b0) hold_on = 1'b1;
        if (done === 1'b1 || !power_ok) hold_on = 1'b0;
        if (power_ok && (hold_on || ce_n === 1'b0) && write_guard_n !== 1'b1) guard_bad++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic sig(input int k);
        return (k == 0) ? cmd_ready : (k == 1) ? done : we_n;
    endfunction

    task automatic wait_lvl(input int k, input logic v);
        int n;
        n = 0;
        while (sig(k) !== v && n < 4000) begin
            @(negedge clk);
            n++;
        end
        chk(n < 4000, 1);
    endtask

    task automatic issue(input ep_cmd_t c, input logic [16:0] a, input logic [7:0] d);
        wait_lvl(0, 1'b1);
        cmd = c;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask

    task automatic run(input ep_cmd_t c, input logic [16:0] a, input logic [7:0] d);
        issue(c, a, d);
        wait_lvl(1, 1'b1);
    endtask

    task automatic t_power();
        repeat (4) @(negedge clk);
        chk({write_guard_n, ce_n, we_n, dq_oe_n, cmd_ready}, 32'h0e);
        reset = 1'b0;
        repeat (3) @(negedge clk);
        chk(write_guard_n, 0);
        power_ok = 1'b1;
        repeat (REL) @(negedge clk);
        chk({write_guard_n, cmd_ready}, 32'h2);
    endtask

    task automatic t_sdp();
        run(EP_CMD_WRITE, 17'h00123, 8'h5a);
        run(EP_CMD_READ, 17'h00123, 8'h00);
        chk({sdp_active, rdata}, 32'h05a);
        run(EP_CMD_SDP_ON, 17'h00000, 8'h00);
        chk({sdp_active, sdp_dev}, 32'h3);
        run(EP_CMD_WRITE, 17'h00456, 8'hc3);
        run(EP_CMD_READ, 17'h00456, 8'h00);
        chk(rdata, 8'hc3);
        run(EP_CMD_SDP_OFF, 17'h00000, 8'h00);
        chk({sdp_active, sdp_dev}, 32'h0);
        run(EP_CMD_READ, `EP_SDP_ADDR_A, 8'h00);
        chk(rdata, 8'hff);
        run(EP_CMD_READ, `EP_SDP_ADDR_B, 8'h00);
        chk(rdata, 8'hff);
        run(EP_CMD_WRITE, 17'h00789, 8'h3c);
        run(EP_CMD_READ, 17'h00789, 8'h00);
        chk({sdp_dev, rdata}, 32'h03c);
    endtask

    task automatic t_abort();
        issue(EP_CMD_WRITE, 17'h00123, 8'ha5);
        wait_lvl(2, 1'b0);
        wait_lvl(2, 1'b1);
        repeat (4) @(negedge clk);
        power_ok = 1'b0;
        repeat (3) @(negedge clk);
        chk({write_guard_n, cmd_ready, done}, 32'h0);
        power_ok = 1'b1;
        run(EP_CMD_READ, 17'h00123, 8'h00);
        chk(rdata, 8'h5a);
        chk(guard_bad, 0);
        chk(viol, 0);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        t_power();
        t_sdp();
        t_abort();
        close_out();
    end

    // The whole run needs about 22 us; some nine times that means a hang.
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule

`default_nettype wire
